// File: hdl/tboc_ctrl.sv
// Overview of operation
// - Code generator and detector work only in T1
// - Sent code is low six transmit bits
// - Send bit starts code insertion at once
// - Generator inserts abort sequence by itself
// - Codes repeat while send bit stays set
// - Receive enable makes register report codes
// - Received code bits preset to all ones
// - New valid code sets change event
// - Filter field selects 1, 3, 5, 7 codes
// - Rising detector reset bit resets code logic
// - Receive register equal to match sets event
// - Transmit buffer emptying sets event
// - Receive buffer filling sets event
// - Eight consecutive ones set abort event
// - Thirty bits without abort set clear event
// - Fifteen idle scaled ticks set clock loss
// - AIS-CI detection in T1 sets event
// - Mask bit one enables matching flag
// - Data-link bytes go out LSB first
// - Flags hold until status register read
`timescale 1ns/100ps
module tboc_ctrl
    import tboc_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Host port
    input  wire logic [7:0] hp_addr,
    input  wire logic [7:0] hp_wdata,
    input  wire logic       hp_wr,
    input  wire logic       hp_rd,
    output logic      [7:0] hp_rdata,
    // Line status
    input  wire logic       t1_mode,
    input  wire logic       transmit_clock_input,
    input  wire logic       mclk_scaled_tick,
    input  wire logic       ais_ci_detect,
    // Data link
    input  wire logic       fdl_tx_slot,
    output logic            fdl_tx_bit,
    input  wire logic       fdl_rx_valid,
    input  wire logic       fdl_rx_bit,
    // Interrupt
    output logic            irq
);
    typedef struct packed {
        logic [4:0]  ctl;
        logic [7:0]  mask;
        logic [7:0]  transmit_link_register;
        logic [7:0]  m1;
        logic [7:0]  m2;
        logic [5:0]  code;
        logic [5:0]  cand;
        logic [2:0]  val;
        logic [4:0]  gap;
        logic [7:0]  rx_byte;
        logic [15:0] win;
        logic [2:0]  bitcnt;
        logic [15:0] tx_sh;
        logic [3:0]  tx_cnt;
        logic        tx_boc;
        logic        tx_bit;
        logic        rbr_q;
        logic        transmit_clock_input_q;
        logic [7:0]  rdata;
    } tboc_state_t;

    tboc_state_t q_r;
    tboc_state_t q_nxt;
    logic [7:0]  ev;
    logic [7:0]  flags;
    logic [7:0]  rd_val;
    logic        stat_rd;
    logic        code_en;
    logic        boc_on;
    logic        det_rst;
    logic        abort_reach;
    logic        clr_reach;
    logic        transmit_clock_loss_reach;

    assign stat_rd = hp_rd && (hp_addr == A_STATUS);
    assign code_en = q_r.ctl[CB_RXEN] && t1_mode;
    assign boc_on  = q_r.ctl[CB_SEND] && t1_mode;
    assign det_rst = q_r.ctl[CB_RST] && !q_r.rbr_q;

    // Run of ones on the received link
    tboc_sat_cnt #(.W(4), .MAX(ABORT_ONES)) u_ones (
        .clk   (clk),
        .rst_b (rst_b),
        .inc   (fdl_rx_valid && fdl_rx_bit),
        .clr   (fdl_rx_valid && !fdl_rx_bit),
        .cnt   (),
        .reach (abort_reach)
    );

    // Link bits since the last abort
    tboc_sat_cnt #(.W(5), .MAX(CLEAR_BITS)) u_clear (
        .clk   (clk),
        .rst_b (rst_b),
        .inc   (fdl_rx_valid),
        .clr   (abort_reach),
        .cnt   (),
        .reach (clr_reach)
    );

    // Scaled ticks since the last transmit clock edge
    tboc_sat_cnt #(.W(4), .MAX(TRANSMIT_CLOCK_LOSS_TICKS)) u_transmit_clock_loss (
        .clk   (clk),
        .rst_b (rst_b),
        .inc   (mclk_scaled_tick),
        .clr   (q_r.transmit_clock_input_q != transmit_clock_input),
        .cnt   (),
        .reach (transmit_clock_loss_reach)
    );

    // Sticky event flags, cleared by a status read
    for (genvar i = 0; i < 8; i++) begin : g_flag
        tboc_evt_flag u_flag (
            .clk   (clk),
            .rst_b (rst_b),
            .set   (ev[i]),
            .clr   (stat_rd),
            .flag  (flags[i])
        );
    end

    // Read data selection; unmapped offsets read zero
    always_comb begin
        case (hp_addr)
            A_STATUS: rd_val = flags;
            A_MASK:   rd_val = q_r.mask;
            A_CTL:    rd_val = {3'h0, q_r.ctl};
            A_RXCODE: rd_val = code_en ? {2'h0, q_r.code} : q_r.rx_byte;
            A_TXREG:  rd_val = q_r.transmit_link_register;
            A_MATCH1: rd_val = q_r.m1;
            A_MATCH2: rd_val = q_r.m2;
            default:  rd_val = 8'h00;
        endcase
    end

    // Next-state logic for host port, generator and detector
    always_comb begin
        logic [15:0] word;
        logic [15:0] win;
        logic [2:0]  need;
        logic        hit;
        word = q_r.tx_sh;
        win  = q_r.win;
        need = FILT_NONE;
        hit  = 1'b0;
        q_nxt = q_r;
        ev = 8'h00;
        q_nxt.rbr_q  = q_r.ctl[CB_RST];
        q_nxt.transmit_clock_input_q = transmit_clock_input;

        // Host writes; upper control bits are not stored
        if (hp_wr) begin
            case (hp_addr)
                A_MASK:   q_nxt.mask = hp_wdata;
                A_CTL:    q_nxt.ctl  = hp_wdata[4:0];
                A_TXREG:  q_nxt.transmit_link_register = hp_wdata;
                A_MATCH1: q_nxt.m1   = hp_wdata;
                A_MATCH2: q_nxt.m2   = hp_wdata;
                default:  ;
            endcase
        end
        if (hp_rd) begin
            q_nxt.rdata = rd_val;
        end

        // Integration filter depth
        case (q_r.ctl[CB_FLT_HI:CB_FLT_LO])
            2'b01:   need = FILT_3;
            2'b10:   need = FILT_5;
            2'b11:   need = FILT_7;
            default: need = FILT_NONE;
        endcase

        // Transmit: a mode change restarts the sequence at the next slot
        if (boc_on != q_r.tx_boc) begin
            q_nxt.tx_boc = boc_on;
            q_nxt.tx_cnt = 4'h0;
        end else if (fdl_tx_slot) begin
            if (q_r.tx_cnt == 4'h0) begin
                if (boc_on) begin
                    // Abort flag first, then 0, code, 0
                    word = {1'b0, q_r.transmit_link_register[5:0], 1'b0, ABORT_SEQ};
                    q_nxt.tx_cnt = BOC_LAST;
                end else begin
                    word = {8'h00, q_r.transmit_link_register};
                    q_nxt.tx_cnt = BYTE_LAST;
                    ev[EV_TXE] = 1'b1;
                end
            end else begin
                q_nxt.tx_cnt = q_r.tx_cnt - 4'h1;
            end
            q_nxt.tx_bit = word[0];
            q_nxt.tx_sh  = {1'b0, word[15:1]};
        end

        // Receive: newest bit enters at the top of the window
        if (fdl_rx_valid) begin
            win = {fdl_rx_bit, q_r.win[15:1]};
            q_nxt.win = win;
            q_nxt.bitcnt = q_r.bitcnt + 3'h1;
            if (!code_en && q_r.bitcnt == 3'h7) begin
                q_nxt.rx_byte = win[15:8];
                ev[EV_FULL] = 1'b1;
                ev[EV_MATCH] = (win[15:8] == q_r.m1) || (win[15:8] == q_r.m2);
            end
            if (q_r.gap != GAP_MAX) begin
                q_nxt.gap = q_r.gap + 5'h01;
            end
            hit = code_en && win[7:0] == ABORT_SEQ && !win[8] && !win[15];
            if (hit) begin
                q_nxt.gap = 5'h00;
                // A repeat counts only if it follows the previous code directly
                if (q_r.gap == GAP_BOC && win[14:9] == q_r.cand) begin
                    if (q_r.val != FILT_7) begin
                        q_nxt.val = q_r.val + 3'h1;
                    end
                end else begin
                    q_nxt.val  = 3'h1;
                    q_nxt.cand = win[14:9];
                end
            end
        end
        if (hit && q_nxt.val >= need && q_nxt.cand != q_r.code) begin
            q_nxt.code = q_nxt.cand;
            ev[EV_CHG] = 1'b1;
            ev[EV_MATCH] = ({2'h0, q_nxt.cand} == q_r.m1) ||
                           ({2'h0, q_nxt.cand} == q_r.m2);
        end

        // Detector reset or disable presets the reported code
        if (det_rst || !code_en) begin
            q_nxt.code = CODE_PRESET;
            q_nxt.cand = CODE_PRESET;
            q_nxt.val  = 3'h0;
            q_nxt.gap  = 5'h00;
            ev[EV_CHG] = 1'b0;
        end

        ev[EV_ABORT] = abort_reach;
        ev[EV_CLR]   = clr_reach;
        ev[EV_TRANSMIT_CLOCK_LOSS]  = transmit_clock_loss_reach;
        ev[EV_AIS]   = ais_ci_detect && t1_mode;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q_r        <= '0;
            q_r.ctl    <= RST_CTL;
            q_r.mask   <= RST_REG;
            q_r.transmit_link_register   <= RST_REG;
            q_r.m1     <= RST_REG;
            q_r.m2     <= RST_REG;
            q_r.code   <= CODE_PRESET;
            q_r.cand   <= CODE_PRESET;
            q_r.rx_byte <= RST_REG;
            q_r.rdata  <= RST_REG;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign hp_rdata   = q_r.rdata;
    assign fdl_tx_bit = q_r.tx_bit;
    assign irq        = |(flags & q_r.mask);

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // Filter depth rebuilt from the control field, apart from the next-state logic
    logic [2:0] need_chk;
    assign need_chk = (q_r.ctl[CB_FLT_HI:CB_FLT_LO] == 2'b00) ? FILT_NONE :
                      (q_r.ctl[CB_FLT_HI:CB_FLT_LO] == 2'b01) ? FILT_3 :
                      (q_r.ctl[CB_FLT_HI:CB_FLT_LO] == 2'b10) ? FILT_5 : FILT_7;

    t1_only_a: assert property (!t1_mode |=> !q_r.tx_boc)
        else $error("generator active outside T1");
    tx_abort_a: assert property (
        (fdl_tx_slot && boc_on && q_r.tx_boc && q_r.tx_cnt == 4'h0) |=> fdl_tx_bit)
        else $error("code sequence does not open with abort ones");
    preset_a: assert property ($rose(q_r.ctl[CB_RST]) |=> ##1 q_r.code == CODE_PRESET)
        else $error("detector reset did not preset code");
    change_a: assert property (
        (q_nxt.code != q_r.code && q_nxt.code != CODE_PRESET) |=> flags[EV_CHG])
        else $error("code change without change event");
    filter_a: assert property ((q_nxt.code != q_r.code && code_en && !det_rst) |->
        q_nxt.val >= need_chk)
        else $error("code validated before filter depth");
    abort_a: assert property (abort_reach |=> flags[EV_ABORT] ##1 1'b1)
        else $error("abort event missing");
    transmit_clock_loss_a: assert property (transmit_clock_loss_reach |=> flags[EV_TRANSMIT_CLOCK_LOSS])
        else $error("clock loss event missing");
    hold_a: assert property (!stat_rd |=> (flags & $past(flags)) == $past(flags))
        else $error("flag dropped without status read");
    irq_a: assert property ((flags & q_r.mask) != 8'h00 |-> irq)
        else $error("unmasked flag without interrupt");

    code_chg_c: cover property ($rose(flags[EV_CHG]));
    tx_start_c: cover property ($rose(q_r.tx_boc));
    abort_c:    cover property ($rose(flags[EV_ABORT]));
endmodule

// File: hdl/tboc_pkg.sv
package tboc_pkg;
    // Host port offsets
    localparam logic [7:0] A_STATUS = 8'h18;
    localparam logic [7:0] A_MASK   = 8'h19;
    localparam logic [7:0] A_CTL    = 8'h1F;
    localparam logic [7:0] A_RXCODE = 8'h50;
    localparam logic [7:0] A_TXREG  = 8'h51;
    localparam logic [7:0] A_MATCH1 = 8'h52;
    localparam logic [7:0] A_MATCH2 = 8'h53;

    // Control register fields
    localparam int CB_SEND   = 0;
    localparam int CB_FLT_LO = 1;
    localparam int CB_FLT_HI = 2;
    localparam int CB_RST    = 3;
    localparam int CB_RXEN   = 4;

    // Event flag positions, shared by status and mask
    localparam int EV_CHG   = 0;
    localparam int EV_MATCH = 1;
    localparam int EV_TXE   = 2;
    localparam int EV_FULL  = 3;
    localparam int EV_ABORT = 4;
    localparam int EV_CLR   = 5;
    localparam int EV_TRANSMIT_CLOCK_LOSS  = 6;
    localparam int EV_AIS   = 7;

    // Reset values
    localparam logic [7:0] RST_REG     = 8'h00;
    localparam logic [4:0] RST_CTL     = 5'h00;
    localparam logic [5:0] CODE_PRESET = 6'h3F;

    // Code framing and counts
    localparam logic [7:0] ABORT_SEQ  = 8'hFF;
    localparam logic [3:0] BOC_LAST   = 4'hF;
    localparam logic [3:0] BYTE_LAST  = 4'h7;
    localparam logic [4:0] GAP_BOC    = 5'h0F;
    localparam logic [4:0] GAP_MAX    = 5'h1F;
    localparam logic [3:0] ABORT_ONES = 4'h8;
    localparam logic [4:0] CLEAR_BITS = 5'h1E;
    localparam logic [3:0] TRANSMIT_CLOCK_LOSS_TICKS = 4'hF;
    localparam logic [2:0] FILT_NONE  = 3'h1;
    localparam logic [2:0] FILT_3     = 3'h3;
    localparam logic [2:0] FILT_5     = 3'h5;
    localparam logic [2:0] FILT_7     = 3'h7;
endpackage

// File: hdl/tboc_evt_flag.sv
`timescale 1ns/100ps
module tboc_evt_flag (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Set and clear
    input  wire logic set,
    input  wire logic clr,
    // Sticky flag
    output logic      flag
);
    typedef struct packed {
        logic flag;
    } tboc_flag_t;

    tboc_flag_t q_r;
    tboc_flag_t q_nxt;

    // Set wins so an event in the clearing read is not lost
    always_comb begin
        q_nxt = q_r;
        q_nxt.flag = set | (q_r.flag & ~clr);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign flag = q_r.flag;
endmodule

// File: hdl/tboc_sat_cnt.sv
`timescale 1ns/100ps
module tboc_sat_cnt #(
    parameter int             W   = 4,
    parameter logic [W-1:0]   MAX = '1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // Count control
    input  wire logic         inc,
    input  wire logic         clr,
    // Status
    output logic [W-1:0]      cnt,
    output logic              reach
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } tboc_cnt_t;

    tboc_cnt_t q_r;
    tboc_cnt_t q_nxt;

    // Saturates at MAX so the reach pulse fires once per run
    always_comb begin
        q_nxt = q_r;
        if (clr) begin
            q_nxt.cnt = '0;
        end else if (inc && q_r.cnt != MAX) begin
            q_nxt.cnt = q_r.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign cnt   = q_r.cnt;
    assign reach = inc & ~clr & (q_r.cnt == MAX - 1'b1);
endmodule

// File: verif/tboc_far_end.sv
`timescale 1ns/100ps
module tboc_far_end (
    // Clock
    input  wire logic clk,
    // Bits towards the block
    output logic      rx_valid,
    output logic      rx_bit,
    // Bits from the block
    output logic      tx_slot,
    input  wire logic tx_bit
);
    logic last;

    // Idle link at time zero
    initial begin
        rx_valid = 1'b0;
        rx_bit   = 1'b0;
        tx_slot  = 1'b0;
        last     = 1'b0;
    end

    // Send n bits LSB first; the released line shows the inverse so no stale bit reads as good
    task automatic send(input logic [15:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            rx_valid = 1'b1;
            rx_bit   = v[i];
            last     = v[i];
        end
        @(negedge clk);
        rx_valid = 1'b0;
        rx_bit   = ~last;
    endtask

    // Offer n slots two cycles apart; first bit out lands in bit 0
    task automatic grab(input int n, output logic [15:0] w);
        w = 16'h0000;
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            tx_slot = 1'b1;
            @(negedge clk);
            tx_slot = 1'b0;
            w[i]    = tx_bit;
        end
    endtask
endmodule

// File: verif/tb_t1_bit_oriented_code_controller.sv
`timescale 1ns/100ps
module tb_t1_bit_oriented_code_controller import tboc_pkg::*;;
    logic        clk      = 1'b0;
    logic        rst_b    = 1'b0;
    logic [7:0]  hp_addr  = 8'h00;
    logic [7:0]  hp_wdata = 8'h00;
    logic        hp_wr    = 1'b0;
    logic        hp_rd    = 1'b0;
    logic        t1_mode  = 1'b1;
    logic        transmit_clock_input_in  = 1'b0;
    logic        tick     = 1'b0;
    logic        ais      = 1'b0;
    logic [7:0]  hp_rdata;
    logic        slot;
    logic        tx_bit;
    logic        rx_valid;
    logic        rx_bit;
    logic        irq;
    logic [15:0] w;
    logic [7:0]  fb;
    int          num_errors  = 0;
    int          check_count = 0;

    // 125 MHz clock
    always #4 clk = ~clk;

    tboc_ctrl i_dut (
        .clk(clk), .rst_b(rst_b), .hp_addr(hp_addr), .hp_wdata(hp_wdata),
        .hp_wr(hp_wr), .hp_rd(hp_rd), .hp_rdata(hp_rdata), .t1_mode(t1_mode),
        .transmit_clock_input(transmit_clock_input_in), .mclk_scaled_tick(tick),
        .ais_ci_detect(ais), .fdl_tx_slot(slot), .fdl_tx_bit(tx_bit),
        .fdl_rx_valid(rx_valid), .fdl_rx_bit(rx_bit), .irq(irq)
    );

    tboc_far_end i_far (
        .clk(clk), .rx_valid(rx_valid), .rx_bit(rx_bit),
        .tx_slot(slot), .tx_bit(tx_bit)
    );

    // Masked compare, counted
    task automatic chk(input logic [15:0] got, input logic [15:0] e, input logic [15:0] m);
        check_count++;
        if ((got & m) !== (e & m)) begin
            num_errors++;
            $display("BAD %0t got %h exp %h", $time, got, e);
        end
    endtask

    // Host write: one strobe cycle, inputs move on the falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        hp_addr  = a;
        hp_wdata = d;
        hp_wr    = 1'b1;
        @(negedge clk);
        hp_wr = 1'b0;
    endtask

    // Host read: data is valid the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        @(negedge clk);
        hp_addr = a;
        hp_rd   = 1'b1;
        @(negedge clk);
        hp_rd = 1'b0;
        chk({8'h00, hp_rdata}, {8'h00, e}, {8'h00, m});
    endtask

    // One-cycle pulses on a line input
    task automatic pulse_tick(input int n);
        repeat (n) begin
            @(negedge clk);
            tick = 1'b1;
            @(negedge clk);
            tick = 1'b0;
        end
    endtask

    task automatic end_sim;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Watchdog against a hung sequence
    initial begin
        repeat (50000) @(posedge clk);
        num_errors++;
        end_sim();
    end

    initial begin
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        // Reset values; unmapped and read-only places
        rd(A_STATUS, 8'h00, 8'hFF);
        rd(A_MASK, 8'h00, 8'hFF);
        rd(A_CTL, 8'h00, 8'hFF);
        rd(A_MATCH2, 8'h00, 8'hFF);
        wr(A_RXCODE, 8'h55);
        rd(A_RXCODE, 8'h00, 8'hFF);
        rd(8'h40, 8'h00, 8'hFF);
        wr(A_MASK, 8'hFF);
        rd(A_MASK, 8'hFF, 8'hFF);
        wr(A_MASK, 8'h00);
        // Sent code: abort, zero, six code bits, zero; upper register bits dropped
        wr(A_TXREG, 8'hEA);
        wr(A_CTL, 8'h01);
        i_far.grab(16, w);
        chk(w, {1'b0, 6'h2A, 1'b0, 8'hFF}, 16'hFFFF);
        i_far.grab(16, w);
        chk(w, {1'b0, 6'h2A, 1'b0, 8'hFF}, 16'hFFFF);
        wr(A_CTL, 8'h00);
        i_far.grab(16, w);
        chk(w, 16'hEAEA, 16'hFFFF);
        rd(A_STATUS, 8'h04, 8'h04);
        // Receive with no filtering
        wr(A_CTL, 8'h10);
        rd(A_RXCODE, 8'h3F, 8'h3F);
        i_far.send({1'b0, 6'h15, 1'b0, 8'hFF}, 16);
        rd(A_STATUS, 8'h11, 8'h11);
        rd(A_RXCODE, 8'h15, 8'h3F);
        rd(A_STATUS, 8'h00, 8'h11);
        // Each filter depth: one word short gives nothing, the last one reports
        wr(A_MATCH1, 8'h0C);
        for (int f = 0; f < 4; f++) begin
            fb = {5'h00, f[1:0], 1'b0};
            wr(A_CTL, 8'h18 | fb);
            wr(A_CTL, 8'h10 | fb);
            rd(A_STATUS, 8'h00, 8'hFF);
            rd(A_RXCODE, 8'h3F, 8'hFF);
            repeat (2 * f) i_far.send({1'b0, 6'h0C, 1'b0, 8'hFF}, 16);
            rd(A_STATUS, 8'h00, 8'h01);
            i_far.send({1'b0, 6'h0C, 1'b0, 8'hFF}, 16);
            rd(A_STATUS, 8'h03, 8'h03);
            rd(A_RXCODE, 8'h0C, 8'h3F);
        end
        // Clear event exactly thirty bits after an abort
        i_far.send(16'h00FF, 16);
        i_far.send(16'h0000, 16);
        i_far.send(16'h0000, 5);
        rd(A_STATUS, 8'h00, 8'h20);
        i_far.send(16'h0000, 1);
        rd(A_STATUS, 8'h20, 8'h20);
        // Byte mode receive fills the register and matches
        wr(A_CTL, 8'h00);
        wr(A_MATCH2, 8'hA5);
        // Byte framing runs on from reset: 310 bits so far, two more realign it
        i_far.send(16'h0000, 2);
        rd(A_STATUS, 8'h00, 8'h02);
        i_far.send(16'h00A5, 8);
        rd(A_STATUS, 8'h0A, 8'h0A);
        rd(A_RXCODE, 8'hA5, 8'hFF);
        // Transmit clock loss after fifteen quiet ticks
        @(negedge clk);
        transmit_clock_input_in = 1'b1;
        rd(A_STATUS, 8'h00, 8'h40);
        pulse_tick(14);
        rd(A_STATUS, 8'h00, 8'h40);
        pulse_tick(1);
        rd(A_STATUS, 8'h40, 8'h40);
        // Interrupt follows flag and mask
        wr(A_MASK, 8'h80);
        chk({15'h0000, irq}, 16'h0000, 16'h0001);
        @(negedge clk);
        ais = 1'b1;
        @(negedge clk);
        ais = 1'b0;
        chk({15'h0000, irq}, 16'h0001, 16'h0001);
        wr(A_MASK, 8'h00);
        chk({15'h0000, irq}, 16'h0000, 16'h0001);
        rd(A_STATUS, 8'h80, 8'h80);
        // Outside T1 neither AIS-CI nor a code change is detected
        t1_mode = 1'b0;
        wr(A_CTL, 8'h18);
        wr(A_CTL, 8'h10);
        @(negedge clk);
        ais = 1'b1;
        @(negedge clk);
        ais = 1'b0;
        i_far.send({1'b0, 6'h0C, 1'b0, 8'hFF}, 16);
        rd(A_STATUS, 8'h00, 8'h81);
        // Code reporting is off, so the register shows the last received byte
        rd(A_RXCODE, 8'h18, 8'hFF);
        end_sim();
    end
endmodule
